// >>> hw/ipic_pkg.sv
// package: offsets, field positions, reset values and carrier types
// assumes a 32-bit classic wishbone slave with registers one per word
package ipic_pkg;

	// ----------------------------------------------------------------
	// geometry
	// ----------------------------------------------------------------
	localparam int OCTAL_PINS = 8;
	localparam int QUAD_PINS  = 4;
	localparam int ADR_W      = 18;
	localparam int IDX_W      = 16;

	// ----------------------------------------------------------------
	// register indices (byte address is index times four)
	// ----------------------------------------------------------------
	localparam logic [IDX_W-1:0] IDX_PRIORITY      = 16'hff20;
	localparam logic [IDX_W-1:0] IDX_IRQ_ENABLE    = 16'hff23;
	localparam logic [IDX_W-1:0] IDX_IRQ_FLAGS     = 16'hff27;
	localparam logic [IDX_W-1:0] IDX_OCTAL_SELECT  = 16'hffc0;
	localparam logic [IDX_W-1:0] IDX_OCTAL_COMPARE = 16'hffc1;
	localparam logic [IDX_W-1:0] IDX_QUAD_COMPARE  = 16'hffc2;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int POS_QUAD_PRI_LO  = 6;
	localparam int POS_OCTAL_PRI_LO = 4;
	localparam int POS_OCTAL_BIT    = 3;
	localparam int POS_QUAD_LO      = 4;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] RST_PRIORITY      = 8'h00;
	localparam logic [7:0] RST_IRQ_ENABLE    = 8'h00;
	localparam logic [7:0] RST_IRQ_FLAGS     = 8'h00;
	localparam logic [7:0] RST_OCTAL_SELECT  = 8'h00;
	localparam logic [7:0] RST_OCTAL_COMPARE = 8'hff;
	localparam logic [3:0] RST_QUAD_COMPARE  = 4'hf;

	// writable and readable bits of enable and flag registers
	localparam logic [7:0] EVENT_BITS_MASK = 8'hf8;

	// ----------------------------------------------------------------
	// carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic             cyc;
		logic             stb;
		logic             we;
		logic [3:0]       sel;
		logic [ADR_W-1:0] adr;
		logic [31:0]      dat;
	} ipic_wb_req_type;

	typedef struct packed {
		logic [7:0] priority_r;
		logic [7:0] enable_r;
		logic [7:0] octal_select;
		logic [7:0] octal_compare;
		logic [3:0] quad_compare;
	} ipic_cfg_type;

endpackage

// >>> hw/ipic_sync.sv
// two-flop pin synchroniser with one more stage for edge detection
// assumes pins are asynchronous to clk
`timescale 1ns/10ps
module ipic_sync
#(
	parameter int W = 8
)
(
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic [W-1:0] pin_async,
	output logic      [W-1:0] level,
	output logic      [W-1:0] level_prev
);

	logic [W-1:0] meta_reg;
	logic [W-1:0] level_reg;
	logic [W-1:0] prev_reg;

	// ----------------------------------------------------------------
	// synchroniser chain
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			meta_reg  <= '0;
			level_reg <= '0;
			prev_reg  <= '0;
		end
		else
		begin
			meta_reg  <= pin_async;
			level_reg <= meta_reg;
			prev_reg  <= level_reg;
		end
	end

	assign level      = level_reg;
	assign level_prev = prev_reg;

endmodule

// >>> hw/ipic_top.sv
// input pin interrupt control: priorities, enables, sticky factor flags,
// octal group match detection and quad pin edge detection
// assumes a classic wishbone master on MCLK; pins are asynchronous
//
// Functional notes
// [R01] priority register: four two-bit fields, reset zero
// [R02] enable bit 3 gates octal group interrupt
// [R03] enable bits 7:4 gate quad pins 3:0
// [R04] flag bits 7:3 report events; 2:0 zero
// [R05] writing one clears a flag; zero keeps
// [R06] select bits include octal pins in condition
// [R07] compare bit one falling, zero rising, reset one
// [R08] octal flag sets on match to mismatch
// [R09] quad pin sets flag on chosen edge
// [R10] any set flag requests interrupt at priority; the code requests only while the flag's enable bit is also set
// [R11] pins pass two flops before detection
//
// Chosen here: the Wishbone register port.
`timescale 1ns/10ps
module ipic_top
#(
	parameter int OCTAL_W = ipic_pkg::OCTAL_PINS,
	parameter int QUAD_W  = ipic_pkg::QUAD_PINS
)
(
	input  wire logic                      MCLK,
	input  wire logic                      RESETN,
	input  wire logic                      CYC_I,
	input  wire logic                      STB_I,
	input  wire logic                      WE_I,
	input  wire logic [3:0]                SEL_I,
	input  wire logic [ipic_pkg::ADR_W-1:0] ADR_I,
	input  wire logic [31:0]               DAT_I,
	output logic      [31:0]               DAT_O,
	output logic                           ACK_O,
	input  wire logic [OCTAL_W-1:0]        OCTAL_INPUT_PINS,
	input  wire logic [QUAD_W-1:0]         QUAD_INPUT_PINS,
	output logic                           INT_O,
	output logic      [1:0]                INT_LEVEL,
	output logic                           OCTAL_GROUP_IRQ,
	output logic      [1:0]                OCTAL_GROUP_LEVEL,
	output logic                           QUAD_GROUP_IRQ,
	output logic      [1:0]                QUAD_GROUP_LEVEL
);

	// ----------------------------------------------------------------
	// bus request bundle
	// ----------------------------------------------------------------
	ipic_pkg::ipic_wb_req_type req;

	assign req.cyc = CYC_I;
	assign req.stb = STB_I;
	assign req.we  = WE_I;
	assign req.sel = SEL_I;
	assign req.adr = ADR_I;
	assign req.dat = DAT_I;

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	logic [7:0]              priority_reg;
	logic [7:0]              priority_next;
	logic [7:0]              enable_reg;
	logic [7:0]              enable_next;
	logic [7:0]              flags_reg;
	logic [7:0]              flags_next;
	logic [7:0]              select_reg;
	logic [7:0]              select_next;
	logic [7:0]              compare_reg;
	logic [7:0]              compare_next;
	logic [3:0]              qcompare_reg;
	logic [3:0]              qcompare_next;
	logic                    ack_reg;
	logic [31:0]             rdata_reg;
	logic                    match_prev_reg;
	ipic_pkg::ipic_cfg_type  cfg;

	assign cfg.priority_r    = priority_reg;
	assign cfg.enable_r      = enable_reg;
	assign cfg.octal_select  = select_reg;
	assign cfg.octal_compare = compare_reg;
	assign cfg.quad_compare  = qcompare_reg;

	// ----------------------------------------------------------------
	// address decode
	// ----------------------------------------------------------------
	wire [ipic_pkg::IDX_W-1:0] idx = req.adr[ipic_pkg::ADR_W-1:2];
	wire        active    = req.cyc & req.stb;
	wire        wr_commit = active & req.we & ack_reg & req.sel[0];
	wire        hit_pri   = (idx == ipic_pkg::IDX_PRIORITY);
	wire        hit_en    = (idx == ipic_pkg::IDX_IRQ_ENABLE);
	wire        hit_flg   = (idx == ipic_pkg::IDX_IRQ_FLAGS);
	wire        hit_sel   = (idx == ipic_pkg::IDX_OCTAL_SELECT);
	wire        hit_cmp   = (idx == ipic_pkg::IDX_OCTAL_COMPARE);
	wire        hit_qcmp  = (idx == ipic_pkg::IDX_QUAD_COMPARE);
	wire [7:0]  wbyte     = req.dat[7:0];

	wire        wr_pri    = wr_commit & hit_pri;
	wire        wr_en     = wr_commit & hit_en;
	wire        wr_flg    = wr_commit & hit_flg;
	wire        wr_sel    = wr_commit & hit_sel;
	wire        wr_cmp    = wr_commit & hit_cmp;
	wire        wr_qcmp   = wr_commit & hit_qcmp;

	// ----------------------------------------------------------------
	// read mux (unmapped reads zero)
	// ----------------------------------------------------------------
	wire [7:0] rbyte =
		hit_pri  ? cfg.priority_r :
		hit_en   ? (cfg.enable_r & ipic_pkg::EVENT_BITS_MASK) :
		hit_flg  ? (flags_reg & ipic_pkg::EVENT_BITS_MASK) : // R04
		hit_sel  ? cfg.octal_select :
		hit_cmp  ? cfg.octal_compare :
		hit_qcmp ? {4'h0, cfg.quad_compare} :
		8'h00;

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	logic [OCTAL_W-1:0] octal_lvl;
	logic [QUAD_W-1:0]  quad_lvl;
	logic [QUAD_W-1:0]  quad_prev;

	ipic_sync #(.W(OCTAL_W)) u_octal_sync // R11
	(
		.clk        (MCLK),
		.rst_n      (RESETN),
		.pin_async  (OCTAL_INPUT_PINS),
		.level      (octal_lvl),
		.level_prev ()
	);

	ipic_sync #(.W(QUAD_W)) u_quad_sync // R11
	(
		.clk        (MCLK),
		.rst_n      (RESETN),
		.pin_async  (QUAD_INPUT_PINS),
		.level      (quad_lvl),
		.level_prev (quad_prev)
	);

	// ----------------------------------------------------------------
	// octal group match and quad pin edge detection
	// ----------------------------------------------------------------
	logic [OCTAL_W-1:0] pin_ok;
	logic [QUAD_W-1:0]  quad_evt;

	genvar gi;
	generate
		for (gi = 0; gi < OCTAL_W; gi++)
		begin : g_octal
			// compare 1: match while high, so falling edge breaks it
			assign pin_ok[gi] = ~cfg.octal_select[gi] |
				(octal_lvl[gi] == cfg.octal_compare[gi]); // R06 R07
		end
		for (gi = 0; gi < QUAD_W; gi++)
		begin : g_quad
			assign quad_evt[gi] = cfg.quad_compare[gi] ?
				(quad_prev[gi] & ~quad_lvl[gi]) :
				(~quad_prev[gi] & quad_lvl[gi]); // R09
		end
	endgenerate

	wire match_all  = &pin_ok;
	wire octal_evt  = match_prev_reg & ~match_all; // R08
	wire octal_en   = cfg.enable_r[ipic_pkg::POS_OCTAL_BIT];
	wire [3:0] quad_en = cfg.enable_r[ipic_pkg::POS_QUAD_LO +: 4];

	// ----------------------------------------------------------------
	// flag set and clear
	// ----------------------------------------------------------------
	wire [7:0] flag_set =
		{quad_evt & quad_en, octal_evt & octal_en, 3'h0}; // R02 R03 R09
	wire [7:0] flag_clr = wr_flg ?
		(wbyte & ipic_pkg::EVENT_BITS_MASK) : 8'h00; // R05

	// set beats clear in the same cycle
	assign flags_next = (flags_reg & ~flag_clr) | flag_set; // R04 R05

	// ----------------------------------------------------------------
	// register next values
	// ----------------------------------------------------------------
	assign priority_next = wr_pri ? wbyte : priority_reg; // R01
	assign enable_next   = wr_en ?
		(wbyte & ipic_pkg::EVENT_BITS_MASK) : enable_reg; // R02 R03
	assign select_next   = wr_sel ? wbyte : select_reg; // R06
	assign compare_next  = wr_cmp ? wbyte : compare_reg; // R07
	assign qcompare_next = wr_qcmp ? wbyte[3:0] : qcompare_reg; // R09

	// ----------------------------------------------------------------
	// interrupt requests
	// ----------------------------------------------------------------
	wire [1:0] octal_pri = cfg.priority_r[ipic_pkg::POS_OCTAL_PRI_LO +: 2];
	wire [1:0] quad_pri  = cfg.priority_r[ipic_pkg::POS_QUAD_PRI_LO +: 2];
	wire [7:0] pending   = flags_reg & cfg.enable_r;
	wire       octal_req = pending[ipic_pkg::POS_OCTAL_BIT];
	wire       quad_req  = |pending[ipic_pkg::POS_QUAD_LO +: 4];

	assign OCTAL_GROUP_IRQ   = octal_req; // R10
	assign QUAD_GROUP_IRQ    = quad_req; // R10
	assign OCTAL_GROUP_LEVEL = octal_pri; // R01 R10
	assign QUAD_GROUP_LEVEL  = quad_pri; // R01 R10
	assign INT_O             = octal_req | quad_req; // R10
	assign INT_LEVEL =
		(octal_req & quad_req) ? ((octal_pri > quad_pri) ? octal_pri : quad_pri) :
		octal_req ? octal_pri :
		quad_req  ? quad_pri  :
		2'h0;

	// ----------------------------------------------------------------
	// bus answer
	// ----------------------------------------------------------------
	assign ACK_O = ack_reg;
	assign DAT_O = rdata_reg;

	always_ff @(posedge MCLK or negedge RESETN)
	begin
		if (!RESETN)
		begin
			ack_reg   <= 1'h0;
			rdata_reg <= 32'h0000_0000;
		end
		else
		begin
			ack_reg   <= active & ~ack_reg;
			rdata_reg <= {24'h00_0000, rbyte};
		end
	end

	// ----------------------------------------------------------------
	// control registers
	// ----------------------------------------------------------------
	always_ff @(posedge MCLK or negedge RESETN)
	begin
		if (!RESETN)
		begin
			priority_reg <= ipic_pkg::RST_PRIORITY; // R01
		end
		else
		begin
			priority_reg <= priority_next;
		end
	end

	always_ff @(posedge MCLK or negedge RESETN)
	begin
		if (!RESETN)
		begin
			enable_reg <= ipic_pkg::RST_IRQ_ENABLE; // R02 R03
		end
		else
		begin
			enable_reg <= enable_next;
		end
	end

	always_ff @(posedge MCLK or negedge RESETN)
	begin
		if (!RESETN)
		begin
			select_reg <= ipic_pkg::RST_OCTAL_SELECT; // R06
		end
		else
		begin
			select_reg <= select_next;
		end
	end

	always_ff @(posedge MCLK or negedge RESETN)
	begin
		if (!RESETN)
		begin
			compare_reg <= ipic_pkg::RST_OCTAL_COMPARE; // R07
		end
		else
		begin
			compare_reg <= compare_next;
		end
	end

	always_ff @(posedge MCLK or negedge RESETN)
	begin
		if (!RESETN)
		begin
			qcompare_reg <= ipic_pkg::RST_QUAD_COMPARE; // R09
		end
		else
		begin
			qcompare_reg <= qcompare_next;
		end
	end

	// ----------------------------------------------------------------
	// event state
	// ----------------------------------------------------------------
	always_ff @(posedge MCLK or negedge RESETN)
	begin
		if (!RESETN)
		begin
			flags_reg      <= ipic_pkg::RST_IRQ_FLAGS;
			match_prev_reg <= 1'h0;
		end
		else
		begin
			flags_reg      <= flags_next;
			match_prev_reg <= match_all; // R08
		end
	end

endmodule

// >>> tb/ipic_chk.sv
// checker: bus handshake, priority fields and interrupt outputs
// assumes the ports of ipic_top; bound at the foot of this file
`timescale 1ns/10ps
module ipic_chk
#(
	parameter int OCTAL_W = 8,
	parameter int QUAD_W  = 4
)
(
	input wire logic                        MCLK,
	input wire logic                        RESETN,
	input wire logic                        CYC_I,
	input wire logic                        STB_I,
	input wire logic                        WE_I,
	input wire logic [3:0]                  SEL_I,
	input wire logic [ipic_pkg::ADR_W-1:0]  ADR_I,
	input wire logic [31:0]                 DAT_I,
	input wire logic [31:0]                 DAT_O,
	input wire logic                        ACK_O,
	input wire logic [OCTAL_W-1:0]          OCTAL_INPUT_PINS,
	input wire logic [QUAD_W-1:0]           QUAD_INPUT_PINS,
	input wire logic                        INT_O,
	input wire logic [1:0]                  INT_LEVEL,
	input wire logic                        OCTAL_GROUP_IRQ,
	input wire logic [1:0]                  OCTAL_GROUP_LEVEL,
	input wire logic                        QUAD_GROUP_IRQ,
	input wire logic [1:0]                  QUAD_GROUP_LEVEL
);
	// ----------------------------------------------------------------
	// helper logic
	// ----------------------------------------------------------------
	logic [OCTAL_W+QUAD_W-1:0] pins_prev;
	logic [2:0]                quiet_cnt;
	wire  [OCTAL_W+QUAD_W-1:0] pins_now = {OCTAL_INPUT_PINS, QUAD_INPUT_PINS};
	wire                       cause    = (pins_now != pins_prev) || (ACK_O && WE_I);
	wire  [1:0]                oct_lv   = OCTAL_GROUP_IRQ ? OCTAL_GROUP_LEVEL : 2'h0;
	wire  [1:0]                quad_lv  = QUAD_GROUP_IRQ ? QUAD_GROUP_LEVEL : 2'h0;
	wire  [1:0]                top_lv   = (oct_lv > quad_lv) ? oct_lv : quad_lv;
	always_ff @(posedge MCLK or negedge RESETN)
	begin
		if (!RESETN)
		begin
			pins_prev <= '0;
			quiet_cnt <= 3'h0;
		end
		else
		begin
			pins_prev <= pins_now;
			quiet_cnt <= cause ? 3'h0 : ((quiet_cnt == 3'h7) ? 3'h7 : quiet_cnt + 3'h1);
		end
	end
	default clocking cb @(posedge MCLK);
	endclocking
	default disable iff (!RESETN);
	sequence wr_s(idx);
		CYC_I && STB_I && WE_I && SEL_I[0] && ADR_I[17:2] == idx ##1 ACK_O;
	endsequence
	sequence rd_s(idx);
		CYC_I && STB_I && !WE_I && ADR_I[17:2] == idx ##1 ACK_O;
	endsequence
	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	ack_once_a: assert property (ACK_O |=> !ACK_O)
		else $error("ack held over one cycle");
	ack_answer_a: assert property (CYC_I && STB_I && !ACK_O |=> ACK_O)
		else $error("ack missing after request");
	pri_write_a: assert property (wr_s(ipic_pkg::IDX_PRIORITY) |=>
		{QUAD_GROUP_LEVEL, OCTAL_GROUP_LEVEL} == $past(DAT_I[7:4])) else $error("level fields");
	flag_read_a: assert property (rd_s(ipic_pkg::IDX_IRQ_FLAGS) |->
		DAT_O[2:0] == 3'h0 && DAT_O[31:8] == 24'h0) else $error("flag read low bits");
	enable_off_a: assert property (wr_s(ipic_pkg::IDX_IRQ_ENABLE) |=>
		(!OCTAL_GROUP_IRQ || $past(DAT_I[3])) && (!QUAD_GROUP_IRQ || $past(|DAT_I[7:4])))
		else $error("masked group still requests");
	irq_any_a: assert property (INT_O == (OCTAL_GROUP_IRQ || QUAD_GROUP_IRQ))
		else $error("interrupt not tied to groups");
	level_pick_a: assert property (INT_LEVEL == top_lv)
		else $error("interrupt level wrong");
	irq_cause_a: assert property ($rose(INT_O) |-> quiet_cnt <= 3'h5)
		else $error("interrupt rose without cause");
endmodule

bind ipic_top ipic_chk #(.OCTAL_W(OCTAL_W), .QUAD_W(QUAD_W)) u_ipic_chk (.*);

// >>> tb/input_port_interrupt_control_bench.sv
// testbench: register access, quad pin edges, octal group match events
// assumes ipic_top with its checker bound; pins driven by the bench
`timescale 1ns/10ps
module input_port_interrupt_control_bench;
	localparam logic [15:0] I_PRI = ipic_pkg::IDX_PRIORITY;
	localparam logic [15:0] I_EN  = ipic_pkg::IDX_IRQ_ENABLE;
	localparam logic [15:0] I_FLG = ipic_pkg::IDX_IRQ_FLAGS;
	localparam logic [15:0] I_SEL = ipic_pkg::IDX_OCTAL_SELECT;
	localparam logic [15:0] I_CMP = ipic_pkg::IDX_OCTAL_COMPARE;
	localparam logic [15:0] I_QCM = ipic_pkg::IDX_QUAD_COMPARE;
	ipic_pkg::ipic_wb_req_type req;
	logic        mclk;
	logic        resetn;
	logic [31:0] dat_o;
	logic        ack_o;
	logic        int_o;
	logic        oct_irq;
	logic        quad_irq;
	logic [1:0]  int_lv;
	logic [1:0]  oct_lv;
	logic [1:0]  quad_lv;
	logic [7:0]  opins;
	logic [3:0]  qpins;
	int          num_errors = 0;
	int          num_checks = 0;
	int          i;

	ipic_top u_ipic_top (.MCLK(mclk), .RESETN(resetn), .CYC_I(req.cyc), .STB_I(req.stb),
		.WE_I(req.we), .SEL_I(req.sel), .ADR_I(req.adr), .DAT_I(req.dat), .DAT_O(dat_o),
		.ACK_O(ack_o), .OCTAL_INPUT_PINS(opins), .QUAD_INPUT_PINS(qpins), .INT_O(int_o),
		.INT_LEVEL(int_lv), .OCTAL_GROUP_IRQ(oct_irq), .OCTAL_GROUP_LEVEL(oct_lv),
		.QUAD_GROUP_IRQ(quad_irq), .QUAD_GROUP_LEVEL(quad_lv));

	initial
	begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end
	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		num_checks++;
		if (g !== e)
		begin
			num_errors++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wb(input logic w, input logic [15:0] idx, input logic [7:0] d,
		output logic [7:0] q);
		int n;
		@(posedge mclk);
		req <= {1'b1, 1'b1, w, 4'hf, idx, 2'b00, 24'h0, d};
		n = 0;
		do
		begin
			@(posedge mclk);
			n++;
		end
		while (ack_o !== 1'b1 && n < 20);
		if (ack_o !== 1'b1)
		begin
			num_errors++;
			end_of_test();
		end
		q = dat_o[7:0];
		req <= '0;
	endtask
	task automatic wr(input logic [15:0] idx, input logic [7:0] d);
		logic [7:0] q;
		wb(1'b1, idx, d, q);
	endtask
	task automatic rchk(input string nm, input logic [15:0] idx, input logic [7:0] e);
		logic [7:0] q;
		wb(1'b0, idx, 8'h00, q);
		chk(nm, e, q);
	endtask
	task automatic ev(input logic [7:0] o, input logic [3:0] qv);
		@(posedge mclk);
		opins <= o;
		qpins <= qv;
		repeat (6) @(posedge mclk);
	endtask
	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial
	begin
		req = '0;
		opins = 8'h00;
		qpins = 4'h0;
		resetn = 1'b0;
		repeat (2) @(posedge mclk);
		resetn <= 1'b1;
		repeat (3) @(posedge mclk);
		rchk("pri", I_PRI, 8'h00);
		rchk("en", I_EN, 8'h00);
		rchk("flags", I_FLG, 8'h00);
		rchk("sel", I_SEL, 8'h00);
		rchk("cmp", I_CMP, 8'hff);
		rchk("qcmp", I_QCM, 8'h0f);
		rchk("unmapped", 16'h1234, 8'h00);
		$display("test reset values done");
		wr(I_PRI, 8'hb4);
		rchk("pri", I_PRI, 8'hb4);
		chk("oct level", 8'h3, oct_lv);
		chk("quad level", 8'h2, quad_lv);
		wr(I_EN, 8'hff);
		rchk("en", I_EN, 8'hf8);
		wr(I_SEL, 8'ha5);
		rchk("sel", I_SEL, 8'ha5);
		wr(I_CMP, 8'h3c);
		rchk("cmp", I_CMP, 8'h3c);
		rchk("flags", I_FLG, 8'h08);
		wr(I_FLG, 8'hf8);
		$display("test register access done");
		wr(I_QCM, 8'h0c);
		ev(8'h00, 4'hc);
		rchk("flags", I_FLG, 8'h00);
		for (i = 0; i < 4; i++)
		begin
			ev(8'h00, qpins ^ 4'(4'h1 << i));
			chk("int", 8'h1, int_o);
			chk("int level", 8'h2, int_lv);
			chk("quad irq", 8'h1, quad_irq);
			wr(I_FLG, ~(8'h10 << i));
			rchk("flags", I_FLG, 8'h10 << i);
			wr(I_FLG, 8'h10 << i);
			rchk("flags", I_FLG, 8'h00);
		end
		wr(I_EN, 8'h08);
		ev(8'h00, 4'h0);
		ev(8'h00, 4'h3);
		rchk("flags", I_FLG, 8'h00);
		$display("test quad pins done");
		wr(I_SEL, 8'h0e);
		wr(I_CMP, 8'h00);
		ev(8'h01, 4'h3);
		rchk("flags", I_FLG, 8'h00);
		ev(8'h03, 4'h3);
		chk("int", 8'h1, int_o);
		chk("int level", 8'h3, int_lv);
		chk("oct irq", 8'h1, oct_irq);
		rchk("flags", I_FLG, 8'h08);
		wr(I_FLG, 8'h08);
		ev(8'h07, 4'h3);
		rchk("flags", I_FLG, 8'h00);
		ev(8'h00, 4'h3);
		wr(I_CMP, 8'h04);
		repeat (6) @(posedge mclk);
		rchk("flags", I_FLG, 8'h08);
		wr(I_FLG, 8'h08);
		ev(8'h04, 4'h3);
		rchk("flags", I_FLG, 8'h00);
		ev(8'h00, 4'h3);
		rchk("flags", I_FLG, 8'h08);
		wr(I_FLG, 8'h08);
		rchk("flags", I_FLG, 8'h00);
		chk("int", 8'h0, int_o);
		$display("test octal group done");
		end_of_test();
	end
endmodule
